// File: verilog/ecpr_pkg.sv
package ecpr_pkg;
  // offsets from the port base
  localparam logic [15:0] OFS_DATA = 16'h0000;
  localparam logic [15:0] OFS_STATUS = 16'h0001;
  localparam logic [15:0] OFS_CTRL = 16'h0002;
  localparam logic [15:0] OFS_FIFO = 16'h0400;
  localparam logic [15:0] OFS_CFGB = 16'h0401;
  localparam logic [15:0] OFS_ECR = 16'h0402;
  // mode field encodings
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_BIDIR = 3'h1;
  localparam logic [2:0] MODE_COMPAT_FIFO_PORT = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_RSVD = 3'h5;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CONFIG = 3'h7;
  // reset and fixed values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [2:0] ECR_MODE_RST = 3'h0;
  localparam logic ECR_SVC_RST = 1'b1;
  localparam logic [7:0] CAPABILITY_WORD_VAL = 8'h10;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // device_control bit positions
  localparam int CTL_STROBE = 0;
  localparam int CTL_LF = 1;
  localparam int CTL_RESET = 2;
  localparam int CTL_SELREQ = 3;
  localparam int CTL_ACKIE = 4;
  localparam int CTL_DIR = 5;
  // extended_control bit positions
  localparam int ECR_MODE_LSB = 5;
  localparam int ECR_ERRIE = 4;
  localparam int ECR_DMAEN = 3;
  localparam int ECR_SVC = 2;
  // fifo and handshake timing
  localparam int FIFO_DEPTH = 16;
  localparam int TX_SPACE_THRESHOLD = 8;
  localparam int RX_FILL_THRESHOLD = 8;
  localparam int CLK_PERIOD_NS = 50;
  localparam int STROBE_MIN_NS = 500;
  localparam int STROBE_CYC = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_SETUP = 5'b00010,
    HS_STROBE = 5'b00100,
    HS_RELEASE = 5'b01000,
    HS_REV_ACK = 5'b10000
  } ecpr_hs_t;

  // peripheral status inputs, levels as on the cable
  typedef struct packed {
    logic busy;
    logic peer_acknowledge_in;
    logic paper_error_in;
    logic select;
    logic fault_in_low;
  } ecpr_status_t;

  // peripheral control outputs, levels as on the cable
  typedef struct packed {
    logic strobe_n;
    logic line_feed_out_n;
    logic peer_reset_out;
    logic select_request_out_n;
  } ecpr_ctrl_t;
endpackage

// File: verilog/ecpr_fifo.sv
`timescale 1ns/1ps
module ecpr_fifo
  import ecpr_pkg::*;
#(
  parameter int W = 9,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic pop_i,
  output logic [W-1:0] head_o,
  output logic [$clog2(DEPTH):0] count_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  wire do_push = push_i && (count_ff != DEPTH_C);
  wire do_pop = pop_i && (count_ff != '0);

  // a push when full is dropped, a pop when empty is ignored
  assign full_o = (count_ff == DEPTH_C);
  assign empty_o = (count_ff == '0);
  assign count_o = count_ff;
  assign head_o = mem_ff[rd_ptr_ff];

  // storage, one flop row per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge mclk_i) begin
      if (do_push && (wr_ptr_ff == AW'(i))) begin
        mem_ff[i] <= wdata_i;
      end
    end
  end

  // pointers and level
  always_ff @(posedge mclk_i) begin
    if (srst_i || flush_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + AW'(do_push);
      rd_ptr_ff <= rd_ptr_ff + AW'(do_pop);
      count_ff <= count_ff + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  AST_FULL_DROP: assert property (@(posedge mclk_i) disable iff (srst_i)
    (full_o && push_i && !pop_i && !flush_i) |=> full_o && (count_o == DEPTH_C))
    else $error("push into full fifo changed its level");
  AST_EMPTY_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
    (empty_o && pop_i && !push_i) |=> empty_o)
    else $error("pop from empty fifo changed its level");
endmodule

// File: verilog/ecpr_regs.sv
`timescale 1ns/1ps
// Function
// - base plus 0..2 and 400h..402h decode, register chosen by mode field.
// - AEN high blocks every register select.
// - mode codes standard, bidir, fifo, ecp, enhanced, reserved, test, config.
// - data register clears on reset, loads on write strobe rise, drives lines.
// - data port read in modes 000/001 returns the data line levels.
// - mode 011 forward offset zero writes enter fifo tagged as address or run-length.
// - status bits 0 to 2 read low.
// - status bits 3 to 6 return fault, select, paper, acknowledge levels.
// - status bit 7 returns busy inverted.
// - reset clears control bits 0 to 5; bits 6 and 7 read zero.
// - control bits 0,1,3 drive pins inverted, save the handshake's bit 0 in 010/011 and bit 1 in 011; bit 2 drives reset straight.
// - with bit 4 set, acknowledge rising edge raises host interrupt request.
// - direction bit ignored in modes 000/010; else 1 means input.
// - mode 010 fifo bytes go out by compatibility handshake.
// - mode 011 sends by ecp handshake forward, fills fifo in reverse.
// - test mode fifo works both ways without peripheral handshake.
// - test fifo drops writes when full, rereads last byte when empty.
// - test fifo reads come from head in order while not empty.
// - service flag sets on free space or fill threshold by direction, only while the DMA enable bit is clear.
// - capability word at 400h in mode 111 reads 10h.
// - option status reads 0, irq line level, then six zeros.
// - one 16 byte fifo serves all fifo modes and both directions.
// - extended control bits 7 to 5 hold the mode field, read and write.
// - reverse run-length count byte repeats the next byte in hardware.
module ecpr_regs
  import ecpr_pkg::*;
#(
  parameter logic [15:0] BASE_ADDR = 16'h0378,
  parameter int TX_THR = TX_SPACE_THRESHOLD,
  parameter int RX_THR = RX_FILL_THRESHOLD
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic aen_i,
  input wire logic host_write_strobe_n_i,
  input wire logic host_read_strobe_n_i,
  input wire logic [7:0] host_data_i,
  output logic [7:0] host_data_o,
  output logic host_data_oe_o,
  input wire logic enhanced_port_enable_i,
  input wire logic [7:0] peripheral_data_lines_i,
  output logic [7:0] peripheral_data_lines_o,
  output logic peripheral_data_lines_oe_o,
  input ecpr_status_t periph_status_i,
  output ecpr_ctrl_t periph_ctrl_o,
  output logic irq_o
);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] DEPTH_C = CW'(FIFO_DEPTH);
  localparam logic [CW-1:0] TX_THR_C = CW'(TX_THR);
  localparam logic [CW-1:0] RX_THR_C = CW'(RX_THR);
  localparam logic [3:0] STROBE_CYC_C = 4'(STROBE_CYC);
  localparam logic [7:0] STB_LEN_C = 8'(STROBE_CYC);

  logic [7:0] data_ff;
  logic [5:0] ctrl_ff;
  logic [2:0] mode_ff;
  logic errie_ff;
  logic dmaen_ff;
  logic svc_ff;
  logic irq_ff;
  logic wr_n_q_ff;
  logic rd_n_q_ff;
  logic ack_q_ff;
  logic [7:0] rdata_ff;
  logic [7:0] last_byte_ff;
  ecpr_hs_t hs_ff;
  logic [7:0] out_byte_ff;
  logic hs_strobe_ff;
  logic hs_lf_ff;
  logic [3:0] hs_cnt_ff;
  logic [6:0] rle_cnt_ff;
  logic [7:0] rle_byte_ff;
  logic rev_cmd_ff;
  logic [7:0] stb_len_ff;
  logic [8:0] fifo_head;
  logic [CW-1:0] fifo_count;
  logic fifo_full;
  logic fifo_empty;

  // address decode, all qualified by AEN
  wire [15:0] offs = io_addr_i - BASE_ADDR;
  wire hit_data = !aen_i && (offs == OFS_DATA);
  wire hit_status = !aen_i && (offs == OFS_STATUS);
  wire hit_ctrl = !aen_i && (offs == OFS_CTRL);
  wire hit_fifo = !aen_i && (offs == OFS_FIFO);
  wire hit_cfgb = !aen_i && (offs == OFS_CFGB);
  wire hit_ecr = !aen_i && (offs == OFS_ECR);
  wire sel_any = hit_data | hit_status | hit_ctrl | hit_fifo | hit_cfgb | hit_ecr;

  // mode qualifiers
  wire mode_spp = (mode_ff == MODE_STD) || (mode_ff == MODE_BIDIR);
  wire mode_ecp = (mode_ff == MODE_ECP);
  wire mode_test = (mode_ff == MODE_TEST);
  wire mode_cfg = (mode_ff == MODE_CONFIG);
  wire dir_in = ctrl_ff[CTL_DIR] && (mode_ff != MODE_STD) && (mode_ff != MODE_COMPAT_FIFO_PORT);
  wire fifo_port_ok = (mode_ff == MODE_COMPAT_FIFO_PORT) || mode_ecp || mode_test;
  wire sel_data_reg = hit_data && mode_spp;
  wire sel_afifo = hit_data && mode_ecp && !dir_in;
  wire sel_fifo = hit_fifo && fifo_port_ok;
  wire sel_capa = hit_fifo && mode_cfg;
  wire sel_cfgb = hit_cfgb && mode_cfg;

  // host strobe edges, the write takes effect at the rising edge
  wire wr_rise = host_write_strobe_n_i && !wr_n_q_ff;
  wire rd_rise = host_read_strobe_n_i && !rd_n_q_ff;
  wire ack_rise = periph_status_i.peer_acknowledge_in && !ack_q_ff;

  // read values
  wire [7:0] status_val = {!periph_status_i.busy, periph_status_i.peer_acknowledge_in,
    periph_status_i.paper_error_in, periph_status_i.select, periph_status_i.fault_in_low, 3'h0};
  wire [7:0] ctrl_val = {2'h0, ctrl_ff};
  wire [7:0] ecr_val = {mode_ff, errie_ff, dmaen_ff, svc_ff, fifo_full, fifo_empty};
  wire [7:0] cfgb_val = {1'b0, irq_ff, 6'h00};
  wire fifo_rd_ok = mode_test || (mode_ecp && dir_in);
  wire [7:0] fifo_rd_val = fifo_empty ? last_byte_ff : fifo_head[7:0];
  wire [7:0] rd_val = sel_data_reg ? peripheral_data_lines_i :
    hit_status ? status_val :
    hit_ctrl ? ctrl_val :
    (sel_fifo && fifo_rd_ok) ? fifo_rd_val :
    sel_capa ? CAPABILITY_WORD_VAL :
    sel_cfgb ? cfgb_val :
    hit_ecr ? ecr_val : ZERO_BYTE;

  // host side fifo traffic
  wire host_push = wr_rise && (sel_afifo || (sel_fifo && (mode_test || !dir_in)));
  wire host_pop = rd_rise && sel_fifo && fifo_rd_ok && !fifo_empty;
  wire host_tag = sel_afifo;

  // handshake enables
  wire hs_fwd_en = (mode_ff == MODE_COMPAT_FIFO_PORT) || (mode_ecp && !dir_in);
  wire hs_rev_en = mode_ecp && dir_in;
  wire hs_active = hs_fwd_en || hs_rev_en;
  wire fwd_start = hs_fwd_en && (hs_ff == HS_IDLE) && !fifo_empty && !periph_status_i.busy;
  wire rev_take = hs_rev_en && (hs_ff == HS_IDLE) && hs_lf_ff && !periph_status_i.peer_acknowledge_in;
  wire rev_cmd = !periph_status_i.busy; // busy low marks a command byte
  wire rev_push_first = rev_take && !rev_cmd; // count and channel bytes are never stored
  wire rev_push_rpt = (hs_ff == HS_REV_ACK) && !rev_cmd_ff && (rle_cnt_ff != '0) && !fifo_full;
  wire hs_push = rev_push_first || rev_push_rpt;
  wire hs_pop = fwd_start;
  wire [8:0] push_word = hs_push ? {1'b0, rev_push_rpt ? rle_byte_ff : peripheral_data_lines_i} :
    {host_tag, host_data_i};

  // mode write check: leave only via 000/001, enhanced only when allowed
  wire [2:0] new_mode = host_data_i[7:5];
  wire mode_legal = (mode_spp || (new_mode == MODE_STD) || (new_mode == MODE_BIDIR))
    && ((new_mode != MODE_EPP) || enhanced_port_enable_i);
  // service condition by direction
  wire [CW-1:0] fifo_free = DEPTH_C - fifo_count;
  wire svc_hit = !dmaen_ff && (dir_in ? (fifo_count >= RX_THR_C) : (fifo_free >= TX_THR_C));

  ecpr_fifo #(
    .W(9),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .flush_i(mode_spp),
    .push_i(host_push || hs_push),
    .wdata_i(push_word),
    .pop_i(host_pop || hs_pop),
    .head_o(fifo_head),
    .count_o(fifo_count),
    .full_o(fifo_full),
    .empty_o(fifo_empty)
  );

  // host bus answer and pin outputs
  assign host_data_o = rdata_ff;
  assign host_data_oe_o = !host_read_strobe_n_i && sel_any;
  assign irq_o = irq_ff;
  assign peripheral_data_lines_o = mode_spp ? data_ff : mode_test ? fifo_rd_val : out_byte_ff;
  assign peripheral_data_lines_oe_o = !dir_in;
  assign periph_ctrl_o.strobe_n = !(hs_active ? hs_strobe_ff : ctrl_ff[CTL_STROBE]);
  assign periph_ctrl_o.line_feed_out_n = !(mode_ecp ? hs_lf_ff : ctrl_ff[CTL_LF]);
  assign periph_ctrl_o.peer_reset_out = ctrl_ff[CTL_RESET];
  assign periph_ctrl_o.select_request_out_n = !ctrl_ff[CTL_SELREQ];

  // edge history and read capture
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_n_q_ff <= 1'b1;
      rd_n_q_ff <= 1'b1;
      ack_q_ff <= 1'b1;
      rdata_ff <= ZERO_BYTE;
      last_byte_ff <= ZERO_BYTE;
    end else begin
      wr_n_q_ff <= host_write_strobe_n_i;
      rd_n_q_ff <= host_read_strobe_n_i;
      ack_q_ff <= periph_status_i.peer_acknowledge_in;
      if (!host_read_strobe_n_i) begin
        rdata_ff <= rd_val;
      end
      if (host_pop) begin
        last_byte_ff <= fifo_head[7:0];
      end
    end
  end

  // data and control registers
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      data_ff <= DATA_RST;
      ctrl_ff <= CTRL_RST;
    end else begin
      if (wr_rise && sel_data_reg) begin
        data_ff <= host_data_i;
      end
      if (wr_rise && hit_ctrl) begin
        ctrl_ff[CTL_ACKIE:CTL_STROBE] <= host_data_i[CTL_ACKIE:CTL_STROBE];
        if (mode_ff == MODE_BIDIR) begin
          ctrl_ff[CTL_DIR] <= host_data_i[CTL_DIR];
        end
      end
    end
  end

  // extended control; hardware setting of the service flag wins over a write
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      mode_ff <= ECR_MODE_RST;
      errie_ff <= 1'b0;
      dmaen_ff <= 1'b0;
      svc_ff <= ECR_SVC_RST;
    end else begin
      if (wr_rise && hit_ecr) begin
        if (mode_legal) begin
          mode_ff <= new_mode;
        end
        errie_ff <= host_data_i[ECR_ERRIE];
        dmaen_ff <= host_data_i[ECR_DMAEN];
        svc_ff <= host_data_i[ECR_SVC];
      end
      if (!svc_ff && svc_hit) begin
        svc_ff <= 1'b1;
      end
    end
  end

  // acknowledge interrupt, held until the status register is read
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      irq_ff <= 1'b0;
    end else if (ctrl_ff[CTL_ACKIE] && ack_rise) begin
      irq_ff <= 1'b1;
    end else if (rd_rise && hit_status) begin
      irq_ff <= 1'b0;
    end
  end

  // peripheral handshake engine
  always_ff @(posedge mclk_i) begin
    if (srst_i || !hs_active) begin
      hs_ff <= HS_IDLE;
      out_byte_ff <= ZERO_BYTE;
      hs_strobe_ff <= 1'b0;
      hs_lf_ff <= 1'b0;
      hs_cnt_ff <= '0;
      rle_cnt_ff <= '0;
      rle_byte_ff <= ZERO_BYTE;
      rev_cmd_ff <= 1'b0;
    end else begin
      case (hs_ff)
        HS_IDLE: begin
          hs_lf_ff <= hs_rev_en && !fifo_full; // host ready in reverse
          if (fwd_start) begin
            out_byte_ff <= fifo_head[7:0];
            hs_lf_ff <= mode_ecp && fifo_head[8]; // address or run-length tag
            hs_ff <= HS_SETUP;
          end else if (rev_take) begin
            hs_lf_ff <= 1'b0;
            rle_byte_ff <= peripheral_data_lines_i;
            rev_cmd_ff <= rev_cmd; // repeats only follow a data byte
            if (rev_cmd && !peripheral_data_lines_i[7]) begin
              rle_cnt_ff <= peripheral_data_lines_i[6:0];
            end
            hs_ff <= HS_REV_ACK;
          end
        end
        HS_SETUP: begin
          hs_strobe_ff <= 1'b1;
          hs_cnt_ff <= STROBE_CYC_C;
          hs_ff <= HS_STROBE;
        end
        HS_STROBE: begin
          if (hs_cnt_ff != '0) begin
            hs_cnt_ff <= hs_cnt_ff - 4'h1;
          end
          if (mode_ecp ? periph_status_i.busy : (hs_cnt_ff == 4'h1)) begin
            hs_strobe_ff <= 1'b0;
            hs_ff <= HS_RELEASE;
          end
        end
        HS_RELEASE: begin
          if (!periph_status_i.busy) begin
            hs_lf_ff <= 1'b0;
            hs_ff <= HS_IDLE;
          end
        end
        HS_REV_ACK: begin
          if (rev_push_rpt) begin
            rle_cnt_ff <= rle_cnt_ff - 7'h01;
          end
          if (periph_status_i.peer_acknowledge_in && (rev_cmd_ff || (rle_cnt_ff == '0))) begin
            hs_ff <= HS_IDLE;
          end
        end
        default: begin
          hs_ff <= HS_IDLE;
        end
      endcase
    end
  end

  AST_AEN_BLOCKS: assert property (@(posedge mclk_i) disable iff (srst_i)
    aen_i |-> !sel_any && !host_data_oe_o)
    else $error("register selected while AEN high");
  AST_DATA_LOAD: assert property (@(posedge mclk_i) disable iff (srst_i)
    (wr_rise && sel_data_reg) |=> (data_ff == $past(host_data_i)) && (peripheral_data_lines_o == data_ff))
    else $error("data register did not take the host byte");
  AST_STATUS_READ: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!host_read_strobe_n_i && hit_status) |=> (rdata_ff[2:0] == 3'h0)
      && (rdata_ff[7] == !$past(periph_status_i.busy)) && (rdata_ff[3] == $past(periph_status_i.fault_in_low)))
    else $error("status read value wrong");
  AST_CTRL_RESET: assert property (@(posedge mclk_i)
    srst_i |=> (ctrl_ff == CTRL_RST) && periph_ctrl_o.strobe_n && periph_ctrl_o.select_request_out_n)
    else $error("control register not cleared by reset");
  AST_ACK_IRQ: assert property (@(posedge mclk_i) disable iff (srst_i)
    (ack_rise && ctrl_ff[CTL_ACKIE]) |=> irq_o ##1 (irq_o || $past(rd_rise && hit_status)))
    else $error("acknowledge edge did not raise the interrupt");
  AST_DIR_FORCED: assert property (@(posedge mclk_i) disable iff (srst_i)
    ((mode_ff == MODE_STD) || (mode_ff == MODE_COMPAT_FIFO_PORT)) |-> peripheral_data_lines_oe_o)
    else $error("data lines released in an output-only mode");
  AST_CAPA_READ: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!host_read_strobe_n_i && sel_capa) |=> (host_data_o == CAPABILITY_WORD_VAL))
    else $error("capability word wrong");
  AST_SVC_SET: assert property (@(posedge mclk_i) disable iff (srst_i)
    (!svc_ff && svc_hit) |=> svc_ff)
    else $error("service flag missed its threshold");
  // strobe width counter, helper for the compatibility strobe check
  always_ff @(posedge mclk_i) begin
    if (srst_i || !hs_strobe_ff) begin
      stb_len_ff <= '0;
    end else if (stb_len_ff != '1) begin
      stb_len_ff <= stb_len_ff + 8'h01;
    end
  end

  AST_COMPAT_STROBE: assert property (@(posedge mclk_i) disable iff (srst_i)
    ((mode_ff == MODE_COMPAT_FIFO_PORT) && $fell(hs_strobe_ff)) |-> (stb_len_ff == STB_LEN_C))
    else $error("compatibility strobe width wrong");
endmodule

// File: verif/ecpr_periph_model.sv
`timescale 1ns/1ps
module ecpr_periph_model
  import ecpr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire ecpr_ctrl_t ctrl_i,
  input wire logic [7:0] lines_i,
  input wire logic [3:0] rsp_dly_i,
  input wire logic [4:0] pins_i,
  output ecpr_status_t status_o,
  output logic [7:0] got_o,
  output logic got_lf_n_o,
  output logic [7:0] low_cyc_o,
  output logic [7:0] got_cnt_o
);
  logic busy_ff;
  logic stb_n_ff;
  logic [3:0] dly_ff;
  // busy comes from the handshake or bench pin 4, the other pins straight from the bench
  assign status_o = {busy_ff | pins_i[4], pins_i[3:0]};
  // interlocked handshake: capture on strobe assert, busy follows strobe after a delay
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_ff <= 1'b0;
      stb_n_ff <= 1'b1;
      dly_ff <= 4'h0;
      got_o <= 8'h00;
      got_lf_n_o <= 1'b1;
      low_cyc_o <= 8'h00;
      got_cnt_o <= 8'h00;
    end else begin
      stb_n_ff <= ctrl_i.strobe_n;
      if (!ctrl_i.strobe_n) begin
        low_cyc_o <= low_cyc_o + 8'h01;
      end
      if (stb_n_ff && !ctrl_i.strobe_n) begin
        got_o <= lines_i;
        got_lf_n_o <= ctrl_i.line_feed_out_n;
        got_cnt_o <= got_cnt_o + 8'h01;
        low_cyc_o <= 8'h01;
      end
      // slow or prompt answer, set by the bench
      if (busy_ff == !ctrl_i.strobe_n) begin
        dly_ff <= 4'h0;
      end else if (dly_ff >= rsp_dly_i) begin
        busy_ff <= !ctrl_i.strobe_n;
        dly_ff <= 4'h0;
      end else begin
        dly_ff <= dly_ff + 4'h1;
      end
    end
  end
endmodule

// File: verif/ecp_parallel_port_registers_tb.sv
`timescale 1ns/1ps
module ecp_parallel_port_registers_tb;
  import ecpr_pkg::*;
  localparam logic [15:0] BASE = 16'h0378;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [15:0] addr = BASE;
  logic aen = 1'b0;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic [7:0] hdi = 8'h00;
  logic enh = 1'b0;
  logic [4:0] pins = 5'h0B;
  logic [7:0] mdl_d = 8'h3C;
  logic [3:0] rsp_dly = 4'h2;
  logic [7:0] hdo;
  logic hoe;
  logic [7:0] pd_o;
  logic pd_oe;
  logic [7:0] pd_line;
  logic irq;
  ecpr_status_t st_w;
  ecpr_ctrl_t ct_w;
  logic [7:0] got;
  logic got_lf_n;
  logic [7:0] low_cyc;
  logic [7:0] got_cnt;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] d;
  logic oe;
  // data lines: device drives unless turned round, then the peripheral drives
  assign pd_line = pd_oe ? pd_o : mdl_d;
  ecpr_regs #(.BASE_ADDR(BASE)) dut (.mclk_i(mclk_i), .srst_i(srst_i), .io_addr_i(addr), .aen_i(aen),
    .host_write_strobe_n_i(wr_n), .host_read_strobe_n_i(rd_n), .host_data_i(hdi), .host_data_o(hdo),
    .host_data_oe_o(hoe), .enhanced_port_enable_i(enh), .peripheral_data_lines_i(pd_line),
    .peripheral_data_lines_o(pd_o), .peripheral_data_lines_oe_o(pd_oe), .periph_status_i(st_w),
    .periph_ctrl_o(ct_w), .irq_o(irq));
  ecpr_periph_model mdl (.mclk_i(mclk_i), .srst_i(srst_i), .ctrl_i(ct_w), .lines_i(pd_line),
    .rsp_dly_i(rsp_dly), .pins_i(pins), .status_o(st_w), .got_o(got), .got_lf_n_o(got_lf_n),
    .low_cyc_o(low_cyc), .got_cnt_o(got_cnt));
  // clock
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // host write: strobe low one cycle, taken at the edge it is seen high, one edge more to settle
  task automatic wr(input logic [15:0] ofs, input logic [7:0] v);
    addr <= BASE + ofs;
    hdi <= v;
    wr_n <= 1'b0;
    @(posedge mclk_i);
    wr_n <= 1'b1;
    @(posedge mclk_i);
    @(posedge mclk_i);
  endtask
  // host read: three cycles low, data taken from a settled capture before the strobe is released
  task automatic rd(input logic [15:0] ofs, output logic [7:0] v, output logic e);
    addr <= BASE + ofs;
    rd_n <= 1'b0;
    @(posedge mclk_i);
    e = hoe;
    repeat (2) @(posedge mclk_i);
    v = hdo;
    rd_n <= 1'b1;
    @(posedge mclk_i);
  endtask
  task automatic crd(input string nm, input logic [15:0] ofs, input logic [7:0] e);
    rd(ofs, d, oe);
    chk(nm, e, d);
  endtask
  task automatic wait_sent(input logic [7:0] n);
    for (int i = 0; i < 400 && !(got_cnt === n && !st_w.busy && ct_w.strobe_n); i++) begin
      @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
    chk("sent_cnt", n, got_cnt);
  endtask
  function automatic logic [7:0] stexp(input logic [4:0] p);
    return {~p[4], p[3:0], 3'h0};
  endfunction
  // hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    chk("ctrl_pins", 8'h0D, {4'h0, ct_w});
    crd("ctrl_rst", OFS_CTRL, 8'h00);
    crd("ecr_rst", OFS_ECR, 8'h05);
    crd("data_rst", OFS_DATA, 8'h00);
    wr(OFS_DATA, 8'hA5);
    chk("pd_out", 8'hA5, pd_o);
    crd("data_rd", OFS_DATA, 8'hA5);
    aen <= 1'b1;
    wr(OFS_DATA, 8'h11);
    rd(OFS_DATA, d, oe);
    chk("aen_oe", 8'h00, {7'h0, oe});
    aen <= 1'b0;
    crd("aen_data", OFS_DATA, 8'hA5);
    // status patterns, ack interrupt disabled
    for (int i = 0; i < 4; i++) begin
      pins <= (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : (i == 2) ? 5'h0A : 5'h15;
      @(posedge mclk_i);
      crd("status", OFS_STATUS, stexp(pins));
    end
    chk("irq_off", 8'h00, {7'h0, irq});
    pins <= 5'h0B;
    wr(OFS_CTRL, 8'hFF);
    crd("ctrl_rd", OFS_CTRL, 8'h1F);
    chk("ctrl_pins1", 8'h02, {4'h0, ct_w});
    wr(OFS_CTRL, 8'h10);
    pins <= 5'h03;
    repeat (2) @(posedge mclk_i);
    pins <= 5'h0B;
    repeat (2) @(posedge mclk_i);
    chk("irq_on", 8'h01, {7'h0, irq});
    wr(OFS_ECR, 8'hE0);
    crd("cap_word", OFS_FIFO, CAPABILITY_WORD_VAL);
    wr(OFS_FIFO, 8'h55);
    crd("cap_ro", OFS_FIFO, 8'h10);
    wr(OFS_CFGB, 8'hFF);
    crd("opt_stat", OFS_CFGB, 8'h40);
    wr(OFS_ECR, 8'h00);
    crd("status_clr", OFS_STATUS, stexp(5'h0B));
    crd("opt_none", OFS_CFGB, 8'h00);
    chk("irq_clr", 8'h00, {7'h0, irq});
    wr(OFS_CTRL, 8'h00);
    // enhanced mode needs the enable; reserved mode maps only the extended control upstairs
    wr(OFS_ECR, 8'h80);
    crd("ecr_epp_off", OFS_ECR, 8'h05);
    enh <= 1'b1;
    wr(OFS_ECR, 8'h80);
    crd("ecr_epp_on", OFS_ECR, 8'h85);
    wr(OFS_ECR, 8'h00);
    wr(OFS_ECR, 8'hA0);
    wr(OFS_FIFO, 8'h77);
    crd("rsvd_fifo", OFS_FIFO, 8'h00);
    crd("ecr_rsvd", OFS_ECR, 8'hA5);
    wr(OFS_ECR, 8'h00);
    // direction only in bidirectional mode, ignored in mode 000
    wr(OFS_ECR, 8'h20);
    wr(OFS_CTRL, 8'h20);
    chk("dir_in_oe", 8'h00, {7'h0, pd_oe});
    crd("data_in", OFS_DATA, 8'h3C);
    wr(OFS_ECR, 8'h00);
    chk("dir_std_oe", 8'h01, {7'h0, pd_oe});
    crd("ctrl_dir", OFS_CTRL, 8'h20);
    wr(OFS_ECR, 8'h20);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_ECR, 8'h00);
    // test fifo: overfill, threshold on the way down, underrun rereads
    wr(OFS_ECR, 8'hC0);
    crd("ecr_svc", OFS_ECR, 8'hC5);
    for (int i = 0; i < 17; i++) wr(OFS_FIFO, 8'h10 + 8'(i));
    wr(OFS_ECR, 8'hC0);
    crd("ecr_full", OFS_ECR, 8'hC2);
    for (int i = 0; i < 16; i++) begin
      crd("loopback_fifo_port", OFS_FIFO, 8'h10 + 8'(i));
      if (i == 6) crd("ecr_free7", OFS_ECR, 8'hC0);
      if (i == 7) crd("ecr_free8", OFS_ECR, 8'hC4);
    end
    crd("ecr_empty", OFS_ECR, 8'hC5);
    crd("loopback_fifo_port_under", OFS_FIFO, 8'h1F);
    wr(OFS_ECR, 8'hE0);
    crd("ecr_keep", OFS_ECR, 8'hC5);
    wr(OFS_ECR, 8'h00);
    // compatibility fifo transfer
    wr(OFS_ECR, 8'h40);
    wr(OFS_FIFO, 8'h5A);
    wait_sent(8'h02);
    chk("compat_fifo_port_byte", 8'h5A, got);
    chk("compat_fifo_port_strobe", 8'(STROBE_CYC), low_cyc);
    wr(OFS_ECR, 8'h00);
    // ecp forward: tagged byte slow, data byte prompt
    wr(OFS_ECR, 8'h60);
    rsp_dly <= 4'h7;
    wr(OFS_DATA, 8'h33);
    wait_sent(8'h03);
    chk("ecp_addr", 8'h33, got);
    chk("ecp_tag", 8'h00, {7'h0, got_lf_n});
    rsp_dly <= 4'h0;
    wr(OFS_FIFO, 8'h44);
    wait_sent(8'h04);
    chk("ecp_data", 8'h44, got);
    chk("ecp_dtag", 8'h01, {7'h0, got_lf_n});
    wr(OFS_ECR, 8'h00);
    // ecp reverse: run-length count byte, then one data byte stored count plus one times
    wr(OFS_ECR, 8'h20);
    wr(OFS_CTRL, 8'h20);
    wr(OFS_ECR, 8'h60);
    mdl_d <= 8'h02;
    pins <= 5'h03;
    repeat (3) @(posedge mclk_i);
    pins <= 5'h0B;
    repeat (3) @(posedge mclk_i);
    mdl_d <= 8'h5A;
    pins <= 5'h13;
    repeat (3) @(posedge mclk_i);
    pins <= 5'h0B;
    repeat (3) @(posedge mclk_i);
    for (int i = 0; i < 3; i++) crd("rle_byte", OFS_FIFO, 8'h5A);
    crd("rle_empty", OFS_ECR, 8'h61);
    summarize();
  end
endmodule
